//--- hw/dtmrb_consts.vh
// Constants for the four-unit DMA request timer bank.
// Assumes inclusion by the bank's single design file only.
`ifndef DTMRB_CONSTS_VH
`define DTMRB_CONSTS_VH

// ==========================================================
// Bus and register layout
`define DTMRB_NUM_UNITS    4
`define DTMRB_ADDR_W       5
`define DTMRB_DATA_W       32
`define DTMRB_UNIT_LSB     3
`define DTMRB_OFS_CTRL     3'h0
`define DTMRB_OFS_REF      3'h1
`define DTMRB_OFS_CAPT     3'h2
`define DTMRB_OFS_COUNT    3'h3
`define DTMRB_OFS_STATUS   3'h4

// ==========================================================
// Control register fields
`define DTMRB_CTL_ENABLE   0
`define DTMRB_CTL_EXTCLK   1
`define DTMRB_CTL_DIV16    2
`define DTMRB_CTL_CAPMODE  3
`define DTMRB_CTL_RESTART  4
`define DTMRB_CTL_OUTEN    5
`define DTMRB_CTL_IRQEN    6
`define DTMRB_CTL_DMAEN    7
`define DTMRB_CTL_EDGE_LO  8
`define DTMRB_CTL_EDGE_HI  9
`define DTMRB_CTL_PRE_LO   16
`define DTMRB_CTL_PRE_HI   23
`define DTMRB_CTL_MASK     32'h00FF_03FF

// ==========================================================
// Status register fields and reset values
`define DTMRB_ST_CAPT      0
`define DTMRB_ST_REF       1
`define DTMRB_RST_CTRL     32'h0000_0000
`define DTMRB_RST_REF      32'hFFFF_FFFF
`define DTMRB_RST_ZERO     32'h0000_0000

// ==========================================================
// Predivider count and capture edge codes
`define DTMRB_PREDIV_LAST  4'hF
`define DTMRB_EDGE_RISE    2'h1
`define DTMRB_EDGE_FALL    2'h2
`define DTMRB_EDGE_BOTH    2'h3

`endif

//--- hw/dtmrb_top.v
// Four independent 32-bit timers with capture, compare and DMA trigger.
// Assumes one 250 MHz system clock, an async active-low reset and
// asynchronous external clock and capture pins.
//
// Behaviour
// - Four independent timers each have a 32-bit counter and a DMA request.
// - Each timer owns its registers, so writing one never affects another.
// - Software picks the system clock or the timer's own external clock pin.
// - On the system clock a predivide of sixteen or one is applied first.
// - An 8-bit prescaler follows and only its ticks advance the counter.
// - Each timer works in input capture or reference compare mode.
// - An event may toggle the output pin, raise an interrupt or ask for DMA.
// - An event in timer n starts DMA channel n.
`timescale 1ns/1ps
`include "dtmrb_consts.vh"

module dtmrb_top (
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_nrst,
    // Register port
    input  wire [4:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    // Timer pins
    input  wire [3:0]  i_timer_ext_clock_in,
    input  wire [3:0]  i_capture_in,
    output wire [3:0]  o_timer_out,
    // Event requests
    output wire [3:0]  o_irq_req,
    output wire [3:0]  o_dma_start
);

    // ======================================================
    // Register map
    // Each unit owns eight word slots; the address is unit*8+offset.
    // Offset 0 holds control, 1 the reference, 2 the capture latch,
    // 3 the running count and 4 the event flags; 5 to 7 read as zero.
    // The capture latch is read only; writes to it are dropped.
    // Control bit 0 enables the unit; while it is low the predivider and
    // the prescaler rest at zero and the count holds its value.
    // Control bit 1 takes ticks from the unit's own clock pin instead of
    // the system clock.
    // Control bit 2 divides the system clock by sixteen; it is ignored
    // while the pin is the source.
    // Control bit 3 selects input capture; when it is low the unit compares.
    // Control bit 4 returns the count to zero at a reference match, so the
    // period becomes the reference plus one prescaled ticks.
    // Control bits 5, 6 and 7 let an event toggle the output pin, hold the
    // interrupt request and pulse the DMA start line.
    // Control bits 9:8 pick the capture edge: 1 rising, 2 falling, 3 both
    // and 0 none.
    // Control bits 23:16 hold the prescale value P; the counter advances
    // once in every P+1 source ticks.
    // Control bits outside these fields are not stored and read as zero.
    // Flag bit 0 marks a capture and bit 1 a reference match; a one written
    // to a flag clears it, but an event in the same cycle keeps it set.
    // Writing any value to the count clears it, so software can restart a
    // measurement without disabling the unit.
    // A pin edge takes two clocks to reach the event logic, both in the
    // synchroniser; the edge history stage adds no clock of its own.
    // Every output follows its event by one clock; the DMA start line is
    // high for one clock per event, so events on successive clocks merge.
    // The external clock pin must stay high and low for longer than one
    // system clock each, or the synchroniser may miss an edge.
    // The compare looks at the count before a tick adds one, so a match on
    // value V fires on the tick that moves the count on from V.
    // A count that is stopped never matches: only ticks test the reference.
    // The interrupt request is a level that stays high while interrupts are
    // enabled and any flag of the unit is set.
    // A control write leaves the flags alone, so software clears them before
    // it enables interrupts again.

    // ======================================================
    // Address split
    wire [1:0]   sel_unit;
    wire [2:0]   sel_reg;
    wire [127:0] all_ctrl;
    wire [127:0] all_ref;
    wire [127:0] all_capt;
    wire [127:0] all_count;
    wire [7:0]   all_status;

    // Upper address bits pick the unit, lower bits the register.
    assign sel_unit = i_addr[4:3];
    assign sel_reg  = i_addr[2:0];

    // ======================================================
    // Timer units
    genvar gi;
    generate
        for (gi = 0; gi < `DTMRB_NUM_UNITS; gi = gi + 1) begin : g_unit
            reg  [31:0] ctrl;
            reg  [31:0] ref_val;
            reg  [31:0] capt;
            reg  [31:0] count;
            reg  [1:0]  status;
            reg  [2:0]  eclk_sync;
            reg  [2:0]  cap_sync;
            reg  [3:0]  prediv;
            reg  [7:0]  pre_cnt;
            reg         out_q;
            reg         irq_q;
            reg         dma_q;
            wire        hit;
            wire        wr_ctrl;
            wire        wr_ref;
            wire        wr_count;
            wire        wr_status;
            wire        en;
            wire        src_tick;
            wire        pre_tick;
            wire        eclk_rise;
            wire        cap_rise;
            wire        cap_fall;
            wire        cap_evt;
            wire        ref_evt;
            wire        any_evt;
            wire [1:0]  edge_sel;
            wire [7:0]  pre_last;

            // Decode writes aimed at this unit alone.
            assign hit       = (sel_unit == gi);
            assign wr_ctrl   = i_wr & hit & (sel_reg == `DTMRB_OFS_CTRL);
            assign wr_ref    = i_wr & hit & (sel_reg == `DTMRB_OFS_REF);
            assign wr_count  = i_wr & hit & (sel_reg == `DTMRB_OFS_COUNT);
            assign wr_status = i_wr & hit & (sel_reg == `DTMRB_OFS_STATUS);
            assign en        = ctrl[`DTMRB_CTL_ENABLE];
            assign edge_sel  = ctrl[`DTMRB_CTL_EDGE_HI:`DTMRB_CTL_EDGE_LO];
            assign pre_last  = ctrl[`DTMRB_CTL_PRE_HI:`DTMRB_CTL_PRE_LO];

            // Edges are taken only from the second and third stages.
            assign eclk_rise = eclk_sync[1] & ~eclk_sync[2];
            assign cap_rise  = cap_sync[1] & ~cap_sync[2];
            assign cap_fall  = ~cap_sync[1] & cap_sync[2];

            // Source tick: external pin edge or the predivided clock.
            assign src_tick = ctrl[`DTMRB_CTL_EXTCLK] ? eclk_rise :
                              (~ctrl[`DTMRB_CTL_DIV16] |
                               (prediv == `DTMRB_PREDIV_LAST));
            // Prescaler divides the source by its field plus one.
            assign pre_tick = en & src_tick & (pre_cnt == pre_last);

            // Mode decides which event kind is live.
            assign cap_evt = en & ctrl[`DTMRB_CTL_CAPMODE] &
                             (((edge_sel == `DTMRB_EDGE_RISE) & cap_rise) |
                              ((edge_sel == `DTMRB_EDGE_FALL) & cap_fall) |
                              ((edge_sel == `DTMRB_EDGE_BOTH) &
                               (cap_rise | cap_fall)));
            assign ref_evt = pre_tick & ~ctrl[`DTMRB_CTL_CAPMODE] &
                             (count == ref_val);
            assign any_evt = cap_evt | ref_evt;

            // Pin synchronisers, two stages plus an edge history stage.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    eclk_sync <= 3'h0;
                    cap_sync  <= 3'h0;
                end else begin
                    eclk_sync <= {eclk_sync[1:0], i_timer_ext_clock_in[gi]};
                    cap_sync  <= {cap_sync[1:0], i_capture_in[gi]};
                end
            end

            // Configuration registers owned by this unit.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    ctrl    <= `DTMRB_RST_CTRL;
                    ref_val <= `DTMRB_RST_REF;
                end else begin
                    if (wr_ctrl) begin
                        ctrl <= i_wdata & `DTMRB_CTL_MASK;
                    end
                    if (wr_ref) begin
                        ref_val <= i_wdata;
                    end
                end
            end

            // Predivider and prescaler; both idle while disabled.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    prediv  <= 4'h0;
                    pre_cnt <= 8'h00;
                end else if (!en) begin
                    prediv  <= 4'h0;
                    pre_cnt <= 8'h00;
                end else begin
                    prediv <= prediv + 4'h1;
                    if (src_tick) begin
                        pre_cnt <= pre_tick ? 8'h00 : pre_cnt + 8'h01;
                    end
                end
            end

            // Counter: a write clears it, prescaler ticks advance it.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    count <= `DTMRB_RST_ZERO;
                end else if (wr_count) begin
                    count <= `DTMRB_RST_ZERO;
                end else if (pre_tick) begin
                    if (ref_evt & ctrl[`DTMRB_CTL_RESTART]) begin
                        count <= `DTMRB_RST_ZERO;
                    end else begin
                        count <= count + 32'h0000_0001;
                    end
                end
            end

            // Capture latch holds the count seen at the input edge.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    capt <= `DTMRB_RST_ZERO;
                end else if (cap_evt) begin
                    capt <= count;
                end
            end

            // Sticky flags: write one clears, a new event wins.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    status <= 2'h0;
                end else begin
                    status[`DTMRB_ST_CAPT] <= cap_evt |
                        (status[`DTMRB_ST_CAPT] &
                         ~(wr_status & i_wdata[`DTMRB_ST_CAPT]));
                    status[`DTMRB_ST_REF] <= ref_evt |
                        (status[`DTMRB_ST_REF] &
                         ~(wr_status & i_wdata[`DTMRB_ST_REF]));
                end
            end

            // Event actions: pin toggle, interrupt level, DMA pulse.
            always @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    out_q <= 1'b0;
                    irq_q <= 1'b0;
                    dma_q <= 1'b0;
                end else begin
                    if (any_evt & ctrl[`DTMRB_CTL_OUTEN]) begin
                        out_q <= ~out_q;
                    end
                    irq_q <= ctrl[`DTMRB_CTL_IRQEN] &
                             (any_evt | (|status &
                              ~(wr_status & (&(status & i_wdata[1:0])
                                | (status == (status & i_wdata[1:0]))))));
                    dma_q <= any_evt & ctrl[`DTMRB_CTL_DMAEN];
                end
            end

            assign o_timer_out[gi] = out_q;
            assign o_irq_req[gi]   = irq_q;
            assign o_dma_start[gi] = dma_q;
            assign all_ctrl[gi*32 +: 32]  = ctrl;
            assign all_ref[gi*32 +: 32]   = ref_val;
            assign all_capt[gi*32 +: 32]  = capt;
            assign all_count[gi*32 +: 32] = count;
            assign all_status[gi*2 +: 2]  = status;
        end
    endgenerate

    // ======================================================
    // Read data
    reg [31:0] next_rdata;

    // Select the addressed register; unmapped offsets read zero.
    always @* begin
        next_rdata = 32'h0000_0000;
        if (i_rd) begin
            case (sel_reg)
                `DTMRB_OFS_CTRL: begin
                    next_rdata = all_ctrl[sel_unit*32 +: 32];
                end
                `DTMRB_OFS_REF: begin
                    next_rdata = all_ref[sel_unit*32 +: 32];
                end
                `DTMRB_OFS_CAPT: begin
                    next_rdata = all_capt[sel_unit*32 +: 32];
                end
                `DTMRB_OFS_COUNT: begin
                    next_rdata = all_count[sel_unit*32 +: 32];
                end
                `DTMRB_OFS_STATUS: begin
                    next_rdata = {30'h0000_0000, all_status[sel_unit*2 +: 2]};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data stands for exactly the cycle after the read strobe.
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= next_rdata;
        end
    end

endmodule // dtmrb_top

//--- verif/dtmrb_checker.sv
// Port-level checks for the four-unit DMA request timer bank.
// Assumes it is bound to dtmrb_top and sees only its ports.
`timescale 1ns/1ps
module dtmrb_checker (
    input logic        i_clk_sys,
    input logic        i_nrst,
    input logic [4:0]  i_addr,
    input logic [31:0] i_wdata,
    input logic        i_wr,
    input logic        i_rd,
    input logic [31:0] o_rdata,
    input logic [3:0]  o_timer_out,
    input logic [3:0]  o_irq_req,
    input logic [3:0]  o_dma_start
);
    // ==========================================================
    // Register port and event outputs, one clock domain.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
    property p_out_rst;
        !$past(i_nrst) |-> (o_timer_out | o_irq_req | o_dma_start) == 4'h0;
    endproperty
    a_out_rst: assert property (p_out_rst)
        else $error("outs after rst");
    property p_cnt_step;
        (i_rd && i_addr[2:0] == 3'h3) ##1 (i_rd && $stable(i_addr)) |=>
            o_rdata == $past(o_rdata) + 32'h0000_0001 ||
            o_rdata == $past(o_rdata) || o_rdata == 32'h0000_0000;
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("count jump");
    property p_st_bits;
        i_rd && i_addr[2:0] == 3'h4 |=> o_rdata[31:2] == 30'h0000_0000;
    endproperty
    a_st_bits: assert property (p_st_bits) else $error("status bits");
    property p_gap_zero;
        i_rd && i_addr[2:0] > 3'h4 |=> o_rdata == 32'h0000_0000;
    endproperty
    a_gap_zero: assert property (p_gap_zero) else $error("gap read");
    property p_ctl_mask;
        i_rd && i_addr[2:0] == 3'h0 |=>
            (o_rdata & ~32'h00FF_03FF) == 32'h0000_0000;
    endproperty
    a_ctl_mask: assert property (p_ctl_mask)
        else $error("ctrl mask");
    property p_ref_back;
        (i_wr && i_addr[2:0] == 3'h1) ##1 (i_rd && i_addr == $past(i_addr))
            |=> o_rdata == $past(i_wdata, 2);
    endproperty
    a_ref_back: assert property (p_ref_back)
        else $error("ref readback");
    property p_irq_drop;
        |($past(o_irq_req) & ~o_irq_req) |->
            $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3);
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq drop");
endmodule // dtmrb_checker

bind dtmrb_top dtmrb_checker i_chk (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_timer_out(o_timer_out), .o_irq_req(o_irq_req),
    .o_dma_start(o_dma_start)
);

//--- verif/dtmrb_dma_model.sv
// Stand-in for the four DMA channels that take the bank's starts.
// Assumes one start line per channel, each a one-cycle pulse.
`timescale 1ns/1ps
module dtmrb_dma_model (
    // Clock, reset and start lines
    input  logic       i_clk_sys,
    input  logic       i_nrst,
    input  logic [3:0] i_start,
    // One note per cycle with a start, naming the highest channel
    output logic       o_seen,
    output logic [1:0] o_chan
);
    // ==========================================================
    // Channel n starts only from its own timer's line.
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_seen <= 1'b0;
            o_chan <= 2'h0;
        end else begin
            o_seen <= |i_start;
            o_chan <= i_start[3] ? 2'h3 : i_start[2] ? 2'h2 :
                      i_start[1] ? 2'h1 : 2'h0;
        end
    end
endmodule // dtmrb_dma_model

//--- verif/dma_request_timer_bank_tb_top.sv
// Self-checking bench for the four-unit DMA request timer bank.
// Assumes dtmrb_top, its bound checker and the DMA channel stand-in.
`timescale 1ns/1ps
module dma_request_timer_bank_tb_top;
    logic        i_clk_sys = 1'b0;
    logic        i_nrst = 1'b0;
    logic [4:0]  i_addr = 5'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [3:0]  i_timer_ext_clock_in = 4'h0;
    logic [3:0]  i_capture_in = 4'h0;
    logic [31:0] o_rdata, r;
    logic [3:0]  o_timer_out, o_irq_req, o_dma_start;
    logic        seen, rd_d = 1'b0;
    logic [1:0]  chan, u, es;
    logic [31:0] rq[$];
    logic [1:0]  dq[$];
    int          bad_count = 0, total_checks = 0, k, kk;

    // ==========================================================
    // Clock, design and DMA stand-in.
    always #2 i_clk_sys = ~i_clk_sys;
    dtmrb_top i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_timer_ext_clock_in(i_timer_ext_clock_in),
        .i_capture_in(i_capture_in), .o_timer_out(o_timer_out),
        .o_irq_req(o_irq_req), .o_dma_start(o_dma_start));
    dtmrb_dma_model i_dma (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_start(o_dma_start), .o_seen(seen), .o_chan(chan));

    // Compares one value and counts the outcome.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus cycles; strobes stay up until the next cycle or idle.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        i_addr <= a;
        rq.push_back(e);
    endtask
    task automatic idle(input int n);
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        i_wr <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
    endtask
    // Waits a bounded time for a start pulse of unit n.
    task automatic wait_dma(input int n, input int lim);
        k = 0;
        while (o_dma_start[n] !== 1'b1 && k < lim) begin
            @(posedge i_clk_sys);
            k++;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compares read data with the oldest noted word.
    task automatic cmp_rd;
        cmp(o_rdata, rq.pop_front());
    endtask
    // Compares a DMA start with the oldest noted unit; an unnoted one fails.
    task automatic cmp_dma;
        cmp(dq.size() == 0, 1'b0);
        cmp(chan, dq.pop_front());
    endtask
    // Matches read data and DMA starts against the oldest note.
    always @(posedge i_clk_sys) begin
        if (rd_d) cmp_rd;
        if (seen) cmp_dma;
        rd_d = i_rd;
    end
    // Cuts a hang short.
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        bad_count++;
        print_verdict;
    end

    // Main sequence: registers, compare mode, capture mode, restart at the reference.
    initial begin
        r = $urandom(32'hf905394f);
        repeat (6) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            u = n[1:0];
            rd({u, 3'h0}, 32'h0000_0000);
            rd({u, 3'h1}, 32'hFFFF_FFFF);
            rd({u, 3'h3}, 32'h0000_0000);
            rd({u, 3'h3}, 32'h0000_0000);
            rd({u, 3'h4}, 32'h0000_0000);
            rd({u, 3'h5 + 3'($urandom_range(2))}, 32'h0000_0000);
            r = $urandom;
            wr({u, 3'h1}, r);
            rd({u, 3'h1}, r);
            r = $urandom & 32'hFFFF_FFFE;
            wr({u, 3'h0}, r);
            rd({u, 3'h0}, r & 32'h00FF_03FF);
            wr({u, 3'h2}, $urandom);
            rd({u, 3'h2}, 32'h0000_0000);
            wr({u, 3'h0}, 32'h0000_0000);
        end
        idle(2);
        $display("test registers done");
        for (int n = 0; n < 4; n++) begin
            u = n[1:0];
            wr({u, 3'h1}, 32'h0000_0003);
            wr({u, 3'h3}, 32'h0000_0000);
            wr({u, 3'h0}, 32'h0001_00E1 | (n[0] ? 32'h0000_0004 : 32'h0));
            dq.push_back(u);
            idle(0);
            wait_dma(n, 400);
            kk = n[0] ? 16 : 1;
            cmp(k >= 6 * kk && k <= 10 * kk + 8, 1'b1);
            idle(1);
            cmp(o_irq_req, 1 << n);
            cmp(o_timer_out, (2 << n) - 1);
            rd({u, 3'h4}, 32'h0000_0002);
            wr({u, 3'h4}, 32'h0000_0002);
            wr({u, 3'h0}, 32'h0000_0000);
            rd({u, 3'h4}, 32'h0000_0000);
            idle(2);
            cmp(o_irq_req, 32'h0000_0000);
        end
        $display("test compare done");
        for (int n = 0; n < 4; n++) begin
            u = n[1:0];
            kk = 1 + $urandom_range(7);
            es = (n == 0) ? 2'h1 : n[1:0];
            wr({u, 3'h0}, 32'h0000_008B | (32'(es) << 8));
            wr({u, 3'h3}, $urandom);
            idle(2);
            repeat (kk) begin
                i_timer_ext_clock_in[n] <= 1'b1;
                repeat (3) @(posedge i_clk_sys);
                i_timer_ext_clock_in[n] <= 1'b0;
                repeat (3) @(posedge i_clk_sys);
            end
            repeat (4) @(posedge i_clk_sys);
            dq.push_back(u);
            i_capture_in[n] <= 1'b1;
            wait_dma(n, 6);
            cmp(k, es[0] ? 4 : 6);
            i_capture_in[n] <= 1'b0;
            if (es[1]) begin
                if (es[0]) dq.push_back(u);
                @(posedge i_clk_sys);
                wait_dma(n, 6);
                cmp(k, 3);
            end
            rd({u, 3'h2}, kk);
            rd({u, 3'h3}, kk);
            rd({u, 3'h4}, 32'h0000_0001);
            wr({u, 3'h4}, 32'h0000_0001);
            wr({u, 3'h3}, $urandom);
            rd({u, 3'h3}, 32'h0000_0000);
            wr({u, 3'h0}, 32'h0000_0000);
            idle(2);
        end
        $display("test capture done");
        // Restart at the reference: the count runs 0, 1, 2 and again.
        wr(5'h11, 32'h0000_0002);
        wr(5'h13, 32'h0000_0000);
        wr(5'h10, 32'h0000_0031);
        for (int j = 0; j < 6; j++) begin
            rd(5'h13, j % 3);
        end
        wr(5'h10, 32'h0000_0000);
        idle(2);
        cmp(o_timer_out, 32'h0000_000F);
        cmp(rq.size() + dq.size(), 0);
        $display("test restart done");
        print_verdict;
    end
endmodule // dma_request_timer_bank_tb_top
